// >>> logic/irt_pkg.sv
`default_nettype none
package irt_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_CTRL = 12'hd00;
  localparam logic [11:0] IDX_BLOW = 12'hd04;
  localparam logic [11:0] IDX_BHIGH = 12'hd05;
  localparam logic [11:0] IDX_WLOW = 12'hd06;
  localparam logic [11:0] IDX_WHIGH = 12'hd07;
  localparam logic [11:0] IDX_AUX = 12'hd10;
  localparam logic [11:0] IDX_IST = 12'hd11;
  localparam logic [11:0] IDX_IMSK = 12'hd12;
  localparam logic [15:0] A_CTRL = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [15:0] A_BLOW = {2'b00, IDX_BLOW, 2'b00};
  localparam logic [15:0] A_BHIGH = {2'b00, IDX_BHIGH, 2'b00};
  localparam logic [15:0] A_WLOW = {2'b00, IDX_WLOW, 2'b00};
  localparam logic [15:0] A_WHIGH = {2'b00, IDX_WHIGH, 2'b00};
  localparam logic [15:0] A_AUX = {2'b00, IDX_AUX, 2'b00};
  localparam logic [15:0] A_IST = {2'b00, IDX_IST, 2'b00};
  localparam logic [15:0] A_IMSK = {2'b00, IDX_IMSK, 2'b00};
  // Control register fields
  localparam int B_RUN = 7;
  localparam int B_SINGLE = 6;
  localparam int B_TO = 5;
  localparam int B_CLK_HI = 4;
  localparam int B_CLK_LO = 3;
  localparam int B_CAPIE = 2;
  localparam int B_TOIE = 1;
  localparam int B_ROUTE = 0;
  // Auxiliary register fields
  localparam int B_PP = 0;
  localparam int B_WRUN = 1;
  localparam int B_WSINGLE = 2;
  // Interrupt status and mask fields
  localparam int I_BTO = 0;
  localparam int I_CAP = 1;
  localparam int I_WTO = 2;
  localparam int IRQ_W = 3;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;
  // Prescaler width covering the divide-by-8 setting
  localparam int PRE_W = 3;
endpackage : irt_pkg
`default_nettype wire

// >>> logic/irt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module irt_prescaler
  import irt_pkg::*;
#(
  parameter int W = PRE_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Control
  input wire logic run,
  input wire logic [1:0] sel,
  // Tick out
  output logic tick
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] mask;

  // Low bits that must all be one for a tick
  always_comb begin
    mask = W'((1 << sel) - 1);
  end

  ////////////////////////////////////////////////////////////////////////
  // Free divider, restarted while the timer is stopped
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      cnt_q <= cnt_q + W'(1);
      tick <= ((cnt_q & mask) == mask);
    end
  end
endmodule : irt_prescaler
`default_nettype wire

// >>> logic/irt_timer.sv
// Overview of operation
// - Word timer load value upper byte comes from the high reload register.
// - Word timer load value lower byte comes from the low reload register.
// - Byte high-level reload counts the interval while byte timer output is one.
// - Byte low-level reload counts the interval while byte timer output is zero.
// - Reload registers clear on power-on reset, survive stop-mode recovery.
// - Clock select and both interrupt enables survive stop-mode recovery.
// - Control bit 7 starts and stops the byte counter.
// - Bit 6 zero, ping-pong off: counter reloads at terminal count and keeps running.
// - Bit 6 one: counter halts at terminal count.
// - Terminal count sets the time-out flag in bit 5, readable.
// - Writing one clears the flag; zero leaves it; power-on reset is the only other thing that clears it.
// - Bits 4:3 select clock divided by 1, 2, 4 or 8.
// - Bit 2 enables the capture interrupt.
// - Bit 1 enables the time-out interrupt.
// - Bit 0 routes byte timer output onto port 3 pin 4.
// - Ping-pong: hardware hands counting between the two timers at terminal count.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module irt_timer
  import irt_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device events
  input wire logic stop_recovery,
  input wire logic capture_event,
  // Port pin
  input wire logic port_data,
  output logic port3_pin4,
  // Timer levels and interrupt
  output logic byte_timer_out,
  output logic word_timer_out,
  output logic irq
);
  // Byte timer control fields
  logic run_q;
  logic single_q;
  logic to_q;
  logic [1:0] prescale_select_q;
  logic capie_q;
  logic toie_q;
  logic route_q;
  // Reload registers
  logic [7:0] byte_low_level_reload_q;
  logic [7:0] byte_high_level_reload_q;
  logic [7:0] word_reload_low_q;
  logic [7:0] word_reload_high_q;
  // Auxiliary control
  logic pp_q;
  logic wrun_q;
  logic wsingle_q;
  // Counters
  logic [7:0] cnt_q;
  logic [15:0] wcnt_q;
  // Interrupt status and mask
  logic [IRQ_W-1:0] ist_q;
  logic [IRQ_W-1:0] imsk_q;
  // Internal strobes
  logic tick;
  logic wr;
  logic byte_tc;
  logic word_tc;
  logic byte_start;
  logic word_start;
  logic [7:0] ctrl_rd;
  logic mapped;
  logic [IRQ_W-1:0] ev;

  ////////////////////////////////////////////////////////////////////////
  // Prescaler for the byte timer
  irt_prescaler #(
    .W(PRE_W)
  ) u_pre (
    .clock(clock),
    .nrst(nrst),
    .run(run_q),
    .sel(prescale_select_q),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus decode and events
  assign wr = psel & penable & pwrite & pready;
  assign ctrl_rd = {run_q, single_q, to_q, prescale_select_q, capie_q, toie_q, route_q};

  // Address match for every implemented register
  always_comb begin
    unique case (paddr)
      A_CTRL, A_BLOW, A_BHIGH, A_WLOW, A_WHIGH, A_AUX, A_IST, A_IMSK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Terminal counts and starts
  assign byte_tc = run_q & tick & (cnt_q <= 8'h01);
  assign word_tc = wrun_q & (wcnt_q <= 16'h0001);
  assign byte_start = (wr & (paddr == A_CTRL) & pwdata[B_RUN] & ~run_q) | (pp_q & word_tc);
  assign word_start = (wr & (paddr == A_AUX) & pwdata[B_WRUN] & ~wrun_q) | (pp_q & byte_tc);

  // Events that may latch interrupt status
  always_comb begin
    ev = RST_IRQ;
    ev[I_BTO] = byte_tc & toie_q;
    ev[I_CAP] = capture_event & capie_q;
    ev[I_WTO] = word_tc;
  end

  ////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait-free access, answer in the access phase
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      unique case (paddr)
        A_CTRL: prdata <= {24'h00_0000, ctrl_rd};
        A_BLOW: prdata <= {24'h00_0000, byte_low_level_reload_q};
        A_BHIGH: prdata <= {24'h00_0000, byte_high_level_reload_q};
        A_WLOW: prdata <= {24'h00_0000, word_reload_low_q};
        A_WHIGH: prdata <= {24'h00_0000, word_reload_high_q};
        A_AUX: prdata <= {29'h0000_0000, wsingle_q, wrun_q, pp_q};
        A_IST: prdata <= {29'h0000_0000, ist_q};
        A_IMSK: prdata <= {29'h0000_0000, imsk_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reload registers, cleared only by power-on reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      byte_low_level_reload_q <= RST_BYTE;
      byte_high_level_reload_q <= RST_BYTE;
      word_reload_low_q <= RST_BYTE;
      word_reload_high_q <= RST_BYTE;
    end else if (wr) begin
      if (paddr == A_BLOW) byte_low_level_reload_q <= pwdata[7:0];
      if (paddr == A_BHIGH) byte_high_level_reload_q <= pwdata[7:0];
      if (paddr == A_WLOW) word_reload_low_q <= pwdata[7:0];
      if (paddr == A_WHIGH) word_reload_high_q <= pwdata[7:0];
    end
  end

  // Retained control fields
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prescale_select_q <= 2'b00;
      capie_q <= 1'b0;
      toie_q <= 1'b0;
    end else if (wr & (paddr == A_CTRL)) begin
      prescale_select_q <= pwdata[B_CLK_HI:B_CLK_LO];
      capie_q <= pwdata[B_CAPIE];
      toie_q <= pwdata[B_TOIE];
    end
  end

  // Fields cleared by stop-mode recovery
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      single_q <= 1'b0;
      route_q <= 1'b0;
      pp_q <= 1'b0;
      wsingle_q <= 1'b0;
    end else if (stop_recovery) begin
      single_q <= 1'b0;
      route_q <= 1'b0;
      pp_q <= 1'b0;
      wsingle_q <= 1'b0;
    end else if (wr) begin
      if (paddr == A_CTRL) begin
        single_q <= pwdata[B_SINGLE];
        route_q <= pwdata[B_ROUTE];
      end
      if (paddr == A_AUX) begin
        pp_q <= pwdata[B_PP];
        wsingle_q <= pwdata[B_WSINGLE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte timer run bit: software and ping-pong hand-off
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      run_q <= 1'b0;
    end else if (stop_recovery) begin
      run_q <= 1'b0;
    end else if (pp_q & word_tc) begin
      run_q <= 1'b1;
    end else if (byte_tc & (single_q | pp_q)) begin
      run_q <= 1'b0;
    end else if (wr & (paddr == A_CTRL)) begin
      run_q <= pwdata[B_RUN];
    end
  end

  // Word timer run bit
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wrun_q <= 1'b0;
    end else if (stop_recovery) begin
      wrun_q <= 1'b0;
    end else if (pp_q & byte_tc) begin
      wrun_q <= 1'b1;
    end else if (word_tc & (wsingle_q | pp_q)) begin
      wrun_q <= 1'b0;
    end else if (wr & (paddr == A_AUX)) begin
      wrun_q <= pwdata[B_WRUN];
    end
  end

  // Time-out flag: set wins over a write-one clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      to_q <= 1'b0;
    end else if (byte_tc) begin
      to_q <= 1'b1;
    end else if (wr & (paddr == A_CTRL) & pwdata[B_TO]) begin
      to_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte counter and output level
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= RST_BYTE;
      byte_timer_out <= 1'b0;
    end else if (byte_start) begin
      cnt_q <= byte_timer_out ? byte_high_level_reload_q : byte_low_level_reload_q;
    end else if (byte_tc) begin
      byte_timer_out <= ~byte_timer_out;
      if (!single_q && !pp_q) begin
        cnt_q <= byte_timer_out ? byte_low_level_reload_q : byte_high_level_reload_q;
      end
    end else if (run_q & tick) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  // Word counter and output level
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wcnt_q <= RST_WORD;
      word_timer_out <= 1'b0;
    end else if (word_start) begin
      wcnt_q <= {word_reload_high_q, word_reload_low_q};
    end else if (word_tc) begin
      word_timer_out <= ~word_timer_out;
      wcnt_q <= {word_reload_high_q, word_reload_low_q};
    end else if (wrun_q) begin
      wcnt_q <= wcnt_q - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port pin routing
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      port3_pin4 <= 1'b0;
    end else begin
      port3_pin4 <= route_q ? byte_timer_out : port_data;
    end
  end

  // Interrupt status, set wins over write-one clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ist_q <= RST_IRQ;
    end else if (wr & (paddr == A_IST)) begin
      ist_q <= (ist_q & ~pwdata[IRQ_W-1:0]) | ev;
    end else begin
      ist_q <= ist_q | ev;
    end
  end

  // Interrupt mask
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      imsk_q <= RST_IRQ;
    end else if (wr & (paddr == A_IMSK)) begin
      imsk_q <= pwdata[IRQ_W-1:0];
    end
  end

  // Level interrupt output
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ist_q & imsk_q);
    end
  end
endmodule : irt_timer
`default_nettype wire

// >>> verification/irt_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module irt_timer_properties
  import irt_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // APB slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Events, pin and levels
  input wire logic stop_recovery,
  input wire logic capture_event,
  input wire logic port_data,
  input wire logic port3_pin4,
  input wire logic byte_timer_out,
  input wire logic word_timer_out,
  input wire logic irq
);
  ////////////////////////////////////////////////////////////
  logic route_q;
  logic mapped;
  // Word addresses that answer without error
  assign mapped = paddr inside {A_CTRL, A_BLOW, A_BHIGH, A_WLOW, A_WHIGH, A_AUX, A_IST, A_IMSK};
  // Shadow of the pin route bit, cleared by stop-mode recovery
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      route_q <= 1'b0;
    end else if (stop_recovery) begin
      route_q <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == A_CTRL) begin
      route_q <= pwdata[B_ROUTE];
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_ready_needs_setup: assert property (!(psel && !penable) |=> !pready)
    else $error("pready without setup");
  chk_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_error_unmapped: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  chk_error_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  chk_rdata_unmapped_zero: assert property (pready && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_pin_route_on: assert property ($past(nrst) && route_q && $past(route_q)
    |-> port3_pin4 == $past(byte_timer_out))
    else $error("pin does not follow timer");
  chk_pin_route_off: assert property ($past(nrst) && !route_q && !$past(route_q)
    |-> port3_pin4 == $past(port_data))
    else $error("pin does not follow port data");
endmodule : irt_timer_properties

bind irt_timer irt_timer_properties irt_timer_properties_i (.clock(clock), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .stop_recovery(stop_recovery), .capture_event(capture_event), .port_data(port_data),
  .port3_pin4(port3_pin4), .byte_timer_out(byte_timer_out), .word_timer_out(word_timer_out), .irq(irq));
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import irt_pkg::*;
;
  typedef struct {logic [15:0] a; logic [31:0] d; logic [31:0] e; logic err;} irt_row_t;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic stop_recovery = 1'b0;
  logic capture_event = 1'b0;
  logic port_data = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, port3_pin4, byte_timer_out, word_timer_out, irq;
  logic [31:0] rd;
  logic er, lv;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  logic [15:0] regs [8] = '{A_CTRL, A_BLOW, A_BHIGH, A_WLOW, A_WHIGH, A_AUX, A_IST, A_IMSK};
  irt_row_t rows [7] = '{'{A_BLOW, 32'ha5, 32'ha5, 1'b0}, '{A_BHIGH, 32'h5a, 32'h5a, 1'b0},
    '{A_WLOW, 32'h3c, 32'h3c, 1'b0}, '{A_WHIGH, 32'hc3, 32'hc3, 1'b0}, '{A_CTRL, 32'h1f, 32'h1f, 1'b0},
    '{16'h3404, 32'hff, 32'h0, 1'b1}, '{A_IMSK, 32'hff, 32'h7, 1'b0}};
  ////////////////////////////////////////////////////////////
  // Device under test
  irt_timer irt_timer_i (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_recovery(stop_recovery), .capture_event(capture_event), .port_data(port_data),
    .port3_pin4(port3_pin4), .byte_timer_out(byte_timer_out), .word_timer_out(word_timer_out), .irq(irq));
  // Clock, moving port data and watchdog
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    port_data <= ~port_data;
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////
  task report_and_stop();
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; holds the request until pready is sampled high
  task apb(input logic [15:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [15:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task rdchk(input logic [15:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    check(rd, e);
  endtask : rdchk
  // Cycles until the timer level changes, level kept in lv
  task span(output int cnt);
    cnt = 0;
    lv = byte_timer_out;
    do begin
      @(posedge clock);
      cnt++;
    end while (byte_timer_out === lv);
  endtask : span
  // Cycles until the word timer level changes
  task wspan(output int cnt);
    logic w;
    cnt = 0;
    w = word_timer_out;
    do begin
      @(posedge clock);
      cnt++;
    end while (word_timer_out === w);
  endtask : wspan
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    foreach (regs[i]) rdchk(regs[i], 32'h0);
    wr(A_CTRL, 32'h20);
    // Table of write and read-back cases
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      apb(rows[i].a, 1'b0, 32'h0);
      check(rd, rows[i].e);
      check(32'(er), 32'(rows[i].err));
    end
    // Stop-mode recovery keeps reloads and retained control fields
    @(posedge clock) stop_recovery <= 1'b1;
    @(posedge clock) stop_recovery <= 1'b0;
    for (int i = 0; i < 4; i++) rdchk(rows[i].a, rows[i].e);
    rdchk(A_CTRL, 32'h1e);
    wr(A_BLOW, 32'h3);
    wr(A_BHIGH, 32'h2);
    wr(A_IMSK, 32'h0);
    // Auto-reload intervals at every prescale setting
    for (int s = 0; s < 4; s++) begin
      wr(A_CTRL, 32'h83 | (s << 3));
      span(n);
      repeat (2) begin
        span(n);
        check(32'(n), (lv ? 32'h2 : 32'h3) << s);
      end
      wr(A_CTRL, 32'h03);
    end
    // A terminal count may land on the stop write; sample the level after it
    @(posedge clock) lv = byte_timer_out;
    repeat (40) @(posedge clock);
    check(32'(byte_timer_out), 32'(lv));
    rdchk(A_CTRL, 32'h23);
    rdchk(A_IST, 32'h1);
    check(32'(irq), 32'h0);
    wr(A_IMSK, 32'h7);
    repeat (3) @(posedge clock);
    check(32'(irq), 32'h1);
    wr(A_CTRL, 32'h23);
    rdchk(A_CTRL, 32'h03);
    wr(A_IST, 32'h1);
    repeat (3) @(posedge clock);
    check(32'(irq), 32'h0);
    // Capture interrupt disabled, then enabled
    for (int c = 0; c < 2; c++) begin
      wr(A_CTRL, 32'h4 * c);
      @(posedge clock) capture_event <= 1'b1;
      @(posedge clock) capture_event <= 1'b0;
      rdchk(A_IST, 32'h2 * c);
      check(32'(irq), 32'(c));
    end
    wr(A_IST, 32'h2);
    // Single pass halts, sets the flag, no interrupt when disabled
    wr(A_CTRL, 32'hc0);
    span(n);
    repeat (4) @(posedge clock);
    rdchk(A_CTRL, 32'h60);
    rdchk(A_IST, 32'h0);
    lv = byte_timer_out;
    repeat (40) @(posedge clock);
    check(32'(byte_timer_out), 32'(lv));
    // Word timer counts its full sixteen-bit load value per level
    wr(A_WHIGH, 32'h1);
    wr(A_WLOW, 32'h2);
    wr(A_AUX, 32'h2);
    wspan(n);
    wspan(n);
    check(32'(n), 32'h102);
    wr(A_AUX, 32'h0);
    // Ping-pong: single-pass timers hand counting to each other
    wr(A_WLOW, 32'h5);
    wr(A_WHIGH, 32'h0);
    wr(A_AUX, 32'h5);
    rdchk(A_AUX, 32'h5);
    wr(A_CTRL, 32'hc0);
    span(n);
    repeat (2) begin
      span(n);
      check(32'(n), 32'h6 + (lv ? 32'h2 : 32'h3));
    end
    // Power-on reset in mid-run clears every register
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    foreach (regs[i]) rdchk(regs[i], 32'h0);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
